// file: tsc_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: registers sit at word indices on a plain strobe port
// Notes:   included by the sequencer control top and the watchdog
`ifndef TSC_REGS_SVH
`define TSC_REGS_SVH

`define TSC_OFF_CTL        4'h0
`define TSC_OFF_CFG        4'h1
`define TSC_OFF_BCAST      4'h2
`define TSC_OFF_SDLIM      4'h3

`define TSC_RST_WORD       16'h0000

`define TSC_CTL_ON         15
`define TSC_CTL_SIDL       13
`define TSC_CTL_TOGL       12
`define TSC_CTL_SWT        10
`define TSC_CTL_SSEN       9
`define TSC_CTL_IVIS       8
`define TSC_CTL_STRT       7
`define TSC_CTL_WDTO       6
`define TSC_CTL_ITM_HI     1
`define TSC_CTL_ITM_LO     0

`define TSC_CFG_CLK_HI     15
`define TSC_CFG_CLK_LO     13
`define TSC_CFG_DIV_HI     12
`define TSC_CFG_DIV_LO     8
`define TSC_CFG_PWD_HI     7
`define TSC_CFG_PWD_LO     4
`define TSC_CFG_WDT_HI     2
`define TSC_CFG_WDT_LO     0

`define TSC_BC_ADC_HI      15
`define TSC_BC_ADC_LO      12
`define TSC_BC_IC_HI       11
`define TSC_BC_IC_LO       8
`define TSC_BC_OCCLK_HI    7
`define TSC_BC_OCCLK_LO    4
`define TSC_BC_OCSYNC_HI   3
`define TSC_BC_OCSYNC_LO   0

// shortest watchdog span, in sequencer clocks, at select code 001
`define TSC_WDT_BASE       10'h008

`endif

// file: tsc_pkg.sv
// Purpose: shared types of the trigger sequencer control block
// Assumes: nothing
// Notes:   constants live in tsc_regs.svh
package tsc_pkg;

   typedef enum logic [1:0] {
      ST_READY = 2'b00,
      ST_WAIT  = 2'b01,
      ST_DELAY = 2'b10
   } tsc_state_t;

   typedef enum logic [2:0] {
      CMD_EMIT_TRIGGER = 3'b000,
      CMD_WAIT_HIGH    = 3'b001,
      CMD_WAIT_LOW     = 3'b010,
      CMD_CTRL_SWTRIG  = 3'b011,
      CMD_CTRL_BCAST   = 3'b100
   } tsc_cmd_t;

endpackage

// file: tsc_tick_if.sv
// Purpose: carries clock selection, sequencer tick and watchdog between parts
// Assumes: single clock domain
// Notes:   top drives configuration, leaves return tick and expiry
`timescale 1ns/1ps
`default_nettype none
interface tsc_tick_if;
   logic       active;
   logic [2:0] clk_sel;
   logic [4:0] div;
   logic       tick;
   logic [2:0] wdt_sel;
   logic       wd_run;
   logic       wd_expire;
   modport top_mp (output active, clk_sel, div, wdt_sel, wd_run, input tick, wd_expire);
   modport div_mp (input active, clk_sel, div, output tick);
   modport wdt_mp (input active, tick, wdt_sel, wd_run, output wd_expire);
endinterface
`default_nettype wire

// file: tsc_clk_div.sv
// Purpose: picks the sequencer clock source and divides it into a tick
// Assumes: source ticks are one-cycle enables on i_sys_clk
// Notes:   reserved source codes give no tick at all
`timescale 1ns/1ps
`default_nettype none
module tsc_clk_div (
   input  wire logic       i_sys_clk,   // system clock
   input  wire logic       i_rst,       // sync reset
   input  wire logic       i_osc_tick,  // oscillator enable
   input  wire logic       i_adc_tick,  // adc conversion clock enable
   input  wire logic [2:0] i_tmr_tick,  // timer 1..3 clock enables
   tsc_tick_if.div_mp      bus          // tick link
);
   logic [4:0] cnt_reg;
   logic       src_tick;

   assign src_tick = (bus.clk_sel == 3'h0) ? 1'b1 :
                     (bus.clk_sel == 3'h1) ? i_osc_tick :
                     (bus.clk_sel == 3'h2) ? i_adc_tick :
                     (bus.clk_sel == 3'h3) ? i_tmr_tick[0] :
                     (bus.clk_sel == 3'h4) ? i_tmr_tick[1] :
                     (bus.clk_sel == 3'h5) ? i_tmr_tick[2] : 1'b0;
   assign bus.tick = bus.active && src_tick && (cnt_reg == bus.div);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || !bus.active)
         cnt_reg <= 5'h0;
      else if (src_tick)
         cnt_reg <= (cnt_reg == bus.div) ? 5'h0 : cnt_reg + 5'h1;
   end
endmodule
`default_nettype wire

// file: tsc_watchdog.sv
// Purpose: sequencer watchdog, counts ticks while a step waits on a trigger
// Assumes: tick is a one-cycle enable
// Notes:   expiry is a one-cycle pulse; the caller holds the sticky flag
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.svh"
module tsc_watchdog (
   input  wire logic  i_sys_clk,   // system clock
   input  wire logic  i_rst,       // sync reset
   tsc_tick_if.wdt_mp bus          // tick link
);
   logic [9:0] cnt_reg;
   logic [9:0] limit;

   assign limit = (bus.wdt_sel == 3'h0) ? 10'h0 :
                  (`TSC_WDT_BASE << (bus.wdt_sel - 3'h1));
   assign bus.wd_expire = bus.wd_run && bus.tick && (limit != 10'h0)
                          && (cnt_reg == limit - 10'h1);

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || !bus.wd_run || !bus.active)
         cnt_reg <= 10'h0;
      else if (bus.tick)
         cnt_reg <= cnt_reg + 10'h1;
   end

   chk_wdt_span : assert property (@(posedge i_sys_clk) disable iff (i_rst)
      bus.wd_expire |-> (cnt_reg == limit - 10'h1) && (bus.wdt_sel != 3'h0))
      else $error("watchdog expired at wrong count");
endmodule
`default_nettype wire

// file: tsc_ctrl.sv
// Purpose: control, configuration and broadcast layer of a trigger sequencer
// Assumes: step commands arrive decoded from a queue outside; inputs are on i_sys_clk
// Notes:   register port answers a read one cycle after the strobe
// What this block does
// - module runs only while enable bit set
// - halt-in-idle stops sequencer on device idle
// - toggle mode inverts addressed trigger output
// - pulse mode emits one pulse per trigger
// - software trigger set by one, consumed by control
// - single-step executes one step then stops
// - visibility on: limit reads return live counter
// - visibility off: limit reads return written value
// - start bit runs steps continuously, clear stops
// - watchdog expiry sets sticky timeout flag
// - modes 10/11 level detect, 11 skips delay
// - modes 00/01 edge detect, 01 skips delay
// - input mode touches only wait commands
// - clock source select picks sequencer clock
// - prescaler divides source by value plus one
// - pulse lasts width field plus one ticks
// - watchdog off at 000, else 8..512 ticks
// - adc broadcast bits pulse outputs 12 to 15
// - capture broadcast bits send sync events
// - compare clock broadcast bits send clock pulses
// - compare trigger broadcast bits send sync events
// - broadcast enables used only by broadcast command
// - configuration read-only while enabled and started
`timescale 1ns/1ps
`default_nettype none
`include "tsc_regs.svh"
module tsc_ctrl #(
   parameter int N_LINES = 16     // trigger inputs and outputs
) (
   input  wire logic               i_sys_clk,    // 100 MHz clock
   input  wire logic               i_rst,        // sync reset, high
   input  wire logic [3:0]         i_addr,       // register index
   input  wire logic [15:0]        i_wr_data,    // write data
   input  wire logic               i_wr_en,      // write strobe
   input  wire logic               i_rd_en,      // read strobe
   output logic      [15:0]        o_rd_data,    // read data, next cycle
   input  wire logic               i_dev_idle,   // device in idle
   input  wire logic               i_osc_tick,   // oscillator clock enable
   input  wire logic               i_adc_tick,   // adc conversion clock enable
   input  wire logic [2:0]         i_tmr_tick,   // timer clock enables
   input  wire logic               i_step_valid, // step offered
   input  wire tsc_pkg::tsc_cmd_t  i_step_kind,  // step command
   input  wire logic [3:0]         i_step_arg,   // line selected by step
   output logic                    o_step_ready, // step accepted this cycle
   output logic                    o_step_done,  // step finished pulse
   input  wire logic [N_LINES-1:0] i_in_trig,    // input triggers
   output logic      [N_LINES-1:0] o_trig_line,  // trigger outputs
   output logic      [3:0]         o_ic_sync,    // capture sync events
   output logic      [3:0]         o_oc_clk,     // compare clock pulses
   output logic      [3:0]         o_oc_sync,    // compare sync events
   output logic                    o_active,     // module running
   output logic                    o_wd_timeout  // sticky watchdog flag
);
   ////////////////////////////////////////////////////////////////////////////
   logic                on_reg, sidl_reg, togl_reg, swt_reg, ssen_reg;
   logic                ivis_reg, strt_reg, wdto_reg;
   logic [1:0]          itm_reg;
   logic [15:0]         cfg_reg, bcast_reg, sdlim_reg, delay_cnt_reg;
   logic [15:0]         rd_word, rd_data_reg;
   tsc_pkg::tsc_state_t state_reg, state_next;
   tsc_pkg::tsc_cmd_t   cmd_reg;
   logic [3:0]          arg_reg;
   logic [N_LINES-1:0]  prev_reg, line_reg, fire_vec;
   logic [3:0]          ic_reg, occlk_reg, ocsync_reg;
   logic [3:0]          pwd;
   logic                active, running, locked, step_take, step_end;
   logic                wr_ctl, wr_cfg, wr_bcast, wr_sdlim;
   logic                in_lvl, in_edge, wait_met, skip_delay, swt_consume;
   tsc_tick_if          tk ();

   assign active     = on_reg && !(sidl_reg && i_dev_idle);
   assign running    = active && strt_reg;
   assign locked     = on_reg && strt_reg;
   assign pwd        = cfg_reg[`TSC_CFG_PWD_HI:`TSC_CFG_PWD_LO];
   assign o_active   = active;
   assign o_step_ready = running && (state_reg == tsc_pkg::ST_READY);
   assign step_take  = i_step_valid && o_step_ready;

   ////////////////////////////////////////////////////////////////////////////
   // clock selection and watchdog
   assign tk.active  = active;
   assign tk.clk_sel = cfg_reg[`TSC_CFG_CLK_HI:`TSC_CFG_CLK_LO];
   assign tk.div     = cfg_reg[`TSC_CFG_DIV_HI:`TSC_CFG_DIV_LO];
   assign tk.wdt_sel = cfg_reg[`TSC_CFG_WDT_HI:`TSC_CFG_WDT_LO];
   assign tk.wd_run  = running && (state_reg == tsc_pkg::ST_WAIT);

   tsc_clk_div u_div (
      .i_sys_clk  (i_sys_clk),
      .i_rst      (i_rst),
      .i_osc_tick (i_osc_tick),
      .i_adc_tick (i_adc_tick),
      .i_tmr_tick (i_tmr_tick),
      .bus        (tk)
   );

   tsc_watchdog u_wdt (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .bus       (tk)
   );

   ////////////////////////////////////////////////////////////////////////////
   // register port
   assign wr_ctl   = i_wr_en && (i_addr == `TSC_OFF_CTL);
   assign wr_cfg   = i_wr_en && (i_addr == `TSC_OFF_CFG) && !locked;
   assign wr_bcast = i_wr_en && (i_addr == `TSC_OFF_BCAST) && !locked;
   assign wr_sdlim = i_wr_en && (i_addr == `TSC_OFF_SDLIM) && !locked;

   always_comb
   begin
      rd_word = 16'h0000;
      if (i_addr == `TSC_OFF_CTL)
      begin
         rd_word[`TSC_CTL_ON]   = on_reg;
         rd_word[`TSC_CTL_SIDL] = sidl_reg;
         rd_word[`TSC_CTL_TOGL] = togl_reg;
         rd_word[`TSC_CTL_SWT]  = swt_reg;
         rd_word[`TSC_CTL_SSEN] = ssen_reg;
         rd_word[`TSC_CTL_IVIS] = ivis_reg;
         rd_word[`TSC_CTL_STRT] = strt_reg;
         rd_word[`TSC_CTL_WDTO] = wdto_reg;
         rd_word[`TSC_CTL_ITM_HI:`TSC_CTL_ITM_LO] = itm_reg;
      end
      else if (i_addr == `TSC_OFF_CFG)
         rd_word = cfg_reg & 16'hfff7;
      else if (i_addr == `TSC_OFF_BCAST)
         rd_word = bcast_reg;
      else if (i_addr == `TSC_OFF_SDLIM)
         rd_word = ivis_reg ? delay_cnt_reg : sdlim_reg;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         rd_data_reg <= `TSC_RST_WORD;
      else if (i_rd_en)
         rd_data_reg <= rd_word;
      else
         rd_data_reg <= 16'h0000;
   end
   assign o_rd_data = rd_data_reg;

   // control bits; hardware sets beat a software clear in the same cycle
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         on_reg   <= 1'b0;
         sidl_reg <= 1'b0;
         togl_reg <= 1'b0;
         ssen_reg <= 1'b0;
         ivis_reg <= 1'b0;
         strt_reg <= 1'b0;
         itm_reg  <= 2'b00;
      end
      else if (wr_ctl)
      begin
         on_reg   <= i_wr_data[`TSC_CTL_ON];
         sidl_reg <= i_wr_data[`TSC_CTL_SIDL];
         togl_reg <= i_wr_data[`TSC_CTL_TOGL];
         ssen_reg <= i_wr_data[`TSC_CTL_SSEN];
         ivis_reg <= i_wr_data[`TSC_CTL_IVIS];
         strt_reg <= i_wr_data[`TSC_CTL_STRT];
         itm_reg  <= i_wr_data[`TSC_CTL_ITM_HI:`TSC_CTL_ITM_LO];
      end
      else if (step_end && ssen_reg)
         strt_reg <= 1'b0;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         swt_reg  <= 1'b0;
         wdto_reg <= 1'b0;
      end
      else
      begin
         swt_reg  <= (wr_ctl && i_wr_data[`TSC_CTL_SWT]) || (swt_reg && !swt_consume);
         wdto_reg <= tk.wd_expire ||
                     (wdto_reg && !(wr_ctl && !i_wr_data[`TSC_CTL_WDTO]));
      end
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         cfg_reg   <= `TSC_RST_WORD;
         bcast_reg <= `TSC_RST_WORD;
         sdlim_reg <= `TSC_RST_WORD;
      end
      else
      begin
         if (wr_cfg)
            cfg_reg <= i_wr_data;
         if (wr_bcast)
            bcast_reg <= i_wr_data;
         if (wr_sdlim)
            sdlim_reg <= i_wr_data;
      end
   end
   assign o_wd_timeout = wdto_reg;

   ////////////////////////////////////////////////////////////////////////////
   // step sequencing: trigger waits follow the input mode, software-trigger waits look at swt_reg
   assign in_lvl   = i_in_trig[arg_reg];
   assign in_edge  = (cmd_reg == tsc_pkg::CMD_WAIT_HIGH) ? (in_lvl && !prev_reg[arg_reg])
                                                          : (!in_lvl && prev_reg[arg_reg]);
   assign wait_met = (cmd_reg == tsc_pkg::CMD_CTRL_SWTRIG) ? swt_reg :
                     itm_reg[1] ? (in_lvl == (cmd_reg == tsc_pkg::CMD_WAIT_HIGH))
                                : in_edge;
   assign skip_delay  = (cmd_reg != tsc_pkg::CMD_CTRL_SWTRIG) && itm_reg[0];
   assign swt_consume = running && tk.tick && (state_reg == tsc_pkg::ST_WAIT)
                        && (cmd_reg == tsc_pkg::CMD_CTRL_SWTRIG) && swt_reg;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         tsc_pkg::ST_READY:
            if (step_take)
               state_next = (i_step_kind == tsc_pkg::CMD_EMIT_TRIGGER ||
                             i_step_kind == tsc_pkg::CMD_CTRL_BCAST) ? tsc_pkg::ST_DELAY
                                                                      : tsc_pkg::ST_WAIT;
         tsc_pkg::ST_WAIT:
            if (tk.wd_expire)
               state_next = tsc_pkg::ST_READY;
            else if (tk.tick && wait_met)
               state_next = skip_delay ? tsc_pkg::ST_READY : tsc_pkg::ST_DELAY;
         tsc_pkg::ST_DELAY:
            if (tk.tick && delay_cnt_reg == sdlim_reg)
               state_next = tsc_pkg::ST_READY;
         default:
            state_next = tsc_pkg::ST_READY;
      endcase
   end
   assign step_end    = running && (state_reg != tsc_pkg::ST_READY)
                        && (state_next == tsc_pkg::ST_READY);
   assign o_step_done = step_end;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || !running)
         state_reg <= tsc_pkg::ST_READY;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         cmd_reg  <= tsc_pkg::CMD_EMIT_TRIGGER;
         arg_reg  <= 4'h0;
         prev_reg <= '0;
      end
      else
      begin
         if (step_take)
         begin
            cmd_reg <= i_step_kind;
            arg_reg <= i_step_arg;
         end
         if (tk.tick)
            prev_reg <= i_in_trig;
      end
   end

   // live step delay counter, visible through the limit register
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || state_reg != tsc_pkg::ST_DELAY)
         delay_cnt_reg <= 16'h0000;
      else if (tk.tick)
         delay_cnt_reg <= delay_cnt_reg + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////
   // trigger outputs and broadcast events
   assign fire_vec = !step_take ? '0 :
                     (i_step_kind == tsc_pkg::CMD_EMIT_TRIGGER) ? (N_LINES'(1) << i_step_arg) :
                     (i_step_kind == tsc_pkg::CMD_CTRL_BCAST) ?
                        (N_LINES'(bcast_reg[`TSC_BC_ADC_HI:`TSC_BC_ADC_LO]) << 12) : '0;

   genvar g;
   generate
      for (g = 0; g < N_LINES; g = g + 1)
      begin : g_line
         logic [3:0] cnt_reg;
         always_ff @(posedge i_sys_clk)
         begin
            if (i_rst || !active)
            begin
               line_reg[g] <= 1'b0;
               cnt_reg     <= 4'h0;
            end
            else if (fire_vec[g] && togl_reg)
               line_reg[g] <= !line_reg[g];
            else if (fire_vec[g])
            begin
               line_reg[g] <= 1'b1;
               cnt_reg     <= pwd;
            end
            else if (line_reg[g] && !togl_reg && tk.tick)
            begin
               if (cnt_reg == 4'h0)
                  line_reg[g] <= 1'b0;
               else
                  cnt_reg <= cnt_reg - 4'h1;
            end
         end
      end
   endgenerate
   assign o_trig_line = line_reg;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst || !(step_take && i_step_kind == tsc_pkg::CMD_CTRL_BCAST))
      begin
         ic_reg     <= 4'h0;
         occlk_reg  <= 4'h0;
         ocsync_reg <= 4'h0;
      end
      else
      begin
         ic_reg     <= bcast_reg[`TSC_BC_IC_HI:`TSC_BC_IC_LO];
         occlk_reg  <= bcast_reg[`TSC_BC_OCCLK_HI:`TSC_BC_OCCLK_LO];
         ocsync_reg <= bcast_reg[`TSC_BC_OCSYNC_HI:`TSC_BC_OCSYNC_LO];
      end
   end
   assign o_ic_sync = ic_reg;
   assign o_oc_clk  = occlk_reg;
   assign o_oc_sync = ocsync_reg;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence s_bcast_take;
      step_take && (i_step_kind == tsc_pkg::CMD_CTRL_BCAST);
   endsequence
   sequence s_wait_met_skip;
      running && (state_reg == tsc_pkg::ST_WAIT) && tk.tick && wait_met
      && !tk.wd_expire && skip_delay;
   endsequence

   chk_off_quiet : assert property (!active |=> o_trig_line == '0)
      else $error("trigger line high while inactive");
   chk_idle_halt : assert property ((on_reg && sidl_reg && i_dev_idle) |-> !o_step_ready)
      else $error("step taken in idle with halt set");
   chk_toggle_flip : assert property ((step_take && togl_reg && active)
      |=> o_trig_line == ($past(o_trig_line) ^ $past(fire_vec)))
      else $error("toggle did not invert line");
   chk_pulse_rise : assert property ((step_take && !togl_reg)
      |=> (o_trig_line & $past(fire_vec)) == $past(fire_vec))
      else $error("pulse did not start");
   chk_pulse_end : assert property ((active && $past(active && !togl_reg)
      && $fell(o_trig_line[3])) |-> $past(tk.tick) && $past(g_line[3].cnt_reg) == 4'h0)
      else $error("pulse ended early");
   chk_swt_keep : assert property ((wr_ctl && i_wr_data[`TSC_CTL_SWT]) |=> swt_reg)
      else $error("software trigger lost");
   chk_single_stop : assert property ((step_end && ssen_reg && !wr_ctl) |=> !strt_reg)
      else $error("single step did not stop");
   chk_vis_read : assert property ((i_rd_en && i_addr == `TSC_OFF_SDLIM)
      |=> o_rd_data == ($past(ivis_reg) ? $past(delay_cnt_reg) : $past(sdlim_reg)))
      else $error("limit read wrong source");
   chk_stop_run : assert property (!strt_reg |-> !o_step_ready)
      else $error("step taken while stopped");
   chk_wdto_set : assert property (tk.wd_expire |=> wdto_reg [*1] ##0 state_reg == tsc_pkg::ST_READY)
      else $error("timeout flag not set");
   chk_skip_delay : assert property (s_wait_met_skip |=> state_reg == tsc_pkg::ST_READY)
      else $error("delay not skipped");
   chk_bcast_ic : assert property (s_bcast_take
      |=> o_ic_sync == $past(bcast_reg[11:8]) && o_oc_sync == $past(bcast_reg[3:0])
          ##1 (o_ic_sync == 4'h0 || $past(step_take)))
      else $error("broadcast event wrong");
   chk_cfg_locked : assert property ((i_wr_en && locked) |=> $stable(cfg_reg) && $stable(bcast_reg))
      else $error("locked register changed");
endmodule
`default_nettype wire

// file: tsc_periph_model.sv
// Purpose: peripheral side, records trigger pulse length and broadcast events
// Assumes: every output of the sequencer is sampled on i_sys_clk
// Notes:   events accumulate, so each broadcast pattern is seen only once
`timescale 1ns/1ps
`default_nettype none
module tsc_periph_model (
   input  wire logic        i_sys_clk, // clock
   input  wire logic [15:0] i_line,    // trigger outputs
   input  wire logic [3:0]  i_ic,      // capture sync
   input  wire logic [3:0]  i_occ,     // compare clock
   input  wire logic [3:0]  i_ocs,     // compare sync
   output logic      [15:0] o_hi_len,  // cycles line 3 stood high, last pulse
   output logic      [15:0] o_evt      // every event seen so far
);
   logic [15:0] run;
   initial
   begin
      run = 16'h0000;
      o_hi_len = 16'h0000;
      o_evt = 16'h0000;
   end
   always @(posedge i_sys_clk)
   begin
      if (i_line[3])
         run <= run + 16'h0001;
      else if (run != 16'h0000)
      begin
         o_hi_len <= run;
         run <= 16'h0000;
      end
      o_evt <= o_evt | {i_line[15:12], i_ic, i_occ, i_ocs};
   end
endmodule
`default_nettype wire

// file: trigger_sequencer_control_bench.sv
// Purpose: register and step-port tests of the sequencer control block
// Assumes: source 000 gives a tick every cycle with divider 0
// Notes:   other clock sources are tied off and stay untested
`timescale 1ns/1ps
`default_nettype none
module trigger_sequencer_control_bench;
   logic clk = 1'b0, rst = 1'b1, wen = 1'b0, ren = 1'b0, idle = 1'b0, sv = 1'b0;
   logic [3:0] ad = 4'h0, sa = 4'h0;
   logic [15:0] wd = 16'h0000, itr = 16'h0000, rdd, ln, hl, ev;
   logic [3:0] ic, occ, ocs;
   logic rdy, dn, act, wto;
   tsc_pkg::tsc_cmd_t sk = tsc_pkg::CMD_EMIT_TRIGGER;
   int n_fail = 0, check_count = 0, wn;
   always #5 clk = ~clk;
   tsc_ctrl dut (.i_sys_clk(clk), .i_rst(rst), .i_addr(ad), .i_wr_data(wd),
      .i_wr_en(wen), .i_rd_en(ren), .o_rd_data(rdd), .i_dev_idle(idle),
      .i_osc_tick(1'b0), .i_adc_tick(1'b0), .i_tmr_tick(3'b000),
      .i_step_valid(sv), .i_step_kind(sk), .i_step_arg(sa), .o_step_ready(rdy),
      .o_step_done(dn), .i_in_trig(itr), .o_trig_line(ln), .o_ic_sync(ic),
      .o_oc_clk(occ), .o_oc_sync(ocs), .o_active(act), .o_wd_timeout(wto));
   tsc_periph_model pm (.i_sys_clk(clk), .i_line(ln), .i_ic(ic), .i_occ(occ),
      .i_ocs(ocs), .o_hi_len(hl), .o_evt(ev));
   ////////////////////////////////////////////////////////////////////////////
   task conclude;
   begin
      $display("checks %0d, errors %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   task check(input string nm, input logic [15:0] s, input logic [15:0] e);
   begin
      check_count++;
      if (s !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
   begin
      @(posedge clk);
      ad <= a;
      wd <= d;
      wen <= 1'b1;
      @(posedge clk);
      wen <= 1'b0;
   end
   endtask
   task rd(input logic [3:0] a, input logic [15:0] e);
   begin
      @(posedge clk);
      ad <= a;
      ren <= 1'b1;
      @(posedge clk);
      ren <= 1'b0;
      @(negedge clk);
      check("read", rdd, e);
   end
   endtask
   // waits stay bounded so a stuck engine shows as a mismatch, not a hang
   task step(input tsc_pkg::tsc_cmd_t k, input logic [3:0] a);
   begin
      @(posedge clk);
      sv <= 1'b1;
      sk <= k;
      sa <= a;
      wn = 0;
      do @(negedge clk); while (rdy !== 1'b1 && ++wn < 50);
      @(posedge clk);
      sv <= 1'b0;
      wn = 0;
      do @(negedge clk); while (dn !== 1'b1 && ++wn < 700);
      check("step done", {15'h0000, dn}, 16'h0001);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      #200000;
      n_fail++;
      conclude();
   end
   initial
   begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(4'h0, 16'h0000);
      rd(4'h1, 16'h0000);
      rd(4'h2, 16'h0000);
      rd(4'h5, 16'h0000);
      wr(4'h1, 16'h0031);
      wr(4'h2, 16'hA5C3);
      wr(4'h3, 16'h0002);
      rd(4'h1, 16'h0031);
      rd(4'h3, 16'h0002);
      wr(4'h0, 16'h8000);
      @(negedge clk);
      check("ready", {15'h0000, rdy}, 16'h0000);
      wr(4'h0, 16'h8080);
      rd(4'h0, 16'h8080);
      wr(4'h1, 16'h0000);
      rd(4'h1, 16'h0031);
      step(tsc_pkg::CMD_EMIT_TRIGGER, 4'h3);
      repeat (8) @(posedge clk);
      check("pulse len", hl, 16'h0004);
      step(tsc_pkg::CMD_CTRL_BCAST, 4'h0);
      repeat (3) @(posedge clk);
      check("events", ev, 16'hA5C3);
      // the edge must come while the step waits, or edge mode never sees it
      fork
         step(tsc_pkg::CMD_WAIT_HIGH, 4'h5);
         begin
            repeat (4) @(posedge clk);
            itr <= 16'h0020;
         end
      join
      check("no timeout", {15'h0000, wto}, 16'h0000);
      step(tsc_pkg::CMD_WAIT_LOW, 4'h5);
      check("wd span", {15'h0000, wn >= 7 && wn <= 10}, 16'h0001);
      rd(4'h0, 16'h80C0);
      wr(4'h0, 16'h8480);
      rd(4'h0, 16'h8480);
      step(tsc_pkg::CMD_CTRL_SWTRIG, 4'h0);
      rd(4'h0, 16'h8080);
      wr(4'h0, 16'h8183);
      step(tsc_pkg::CMD_WAIT_HIGH, 4'h5);
      check("level skip", 16'(wn), 16'h0000);
      fork
         step(tsc_pkg::CMD_EMIT_TRIGGER, 4'h3);
         begin
            repeat (2) @(posedge clk);
            rd(4'h3, 16'h0001);
         end
      join
      wr(4'h0, 16'h9083);
      step(tsc_pkg::CMD_EMIT_TRIGGER, 4'h7);
      repeat (6) @(posedge clk);
      check("toggle on", ln, 16'h0080);
      step(tsc_pkg::CMD_EMIT_TRIGGER, 4'h7);
      repeat (6) @(posedge clk);
      check("toggle off", ln, 16'h0000);
      wr(4'h0, 16'h8280);
      step(tsc_pkg::CMD_EMIT_TRIGGER, 4'h3);
      rd(4'h0, 16'h8200);
      wr(4'h0, 16'hA000);
      idle <= 1'b1;
      @(negedge clk);
      check("idle halt", {15'h0000, act}, 16'h0000);
      wr(4'h0, 16'h8000);
      @(negedge clk);
      check("idle run", {15'h0000, act}, 16'h0001);
      wr(4'h0, 16'h0000);
      @(negedge clk);
      check("disabled", {15'h0000, act}, 16'h0000);
      conclude();
   end
endmodule
`default_nettype wire
